// >>> hw/mag_seq_pkg.sv
// Behaviour
// R1 - mode code 00001 runs one measurement, stores results, returns to power-down, clears mode
// R2 - single measurement completion into power-down sets the result ready flag
// R3 - any result register or second status read clears the result ready flag
// R4 - a set ready flag survives leaving power-down; only data reads clear it
// R5 - ready output pin always equals the result ready flag
// R6 - results keep previous values while a measurement runs
// R7 - periodic codes 00010..01100 select 10, 20, 50, 100, 200 and 1 Hz
// R8 - between periodic measurements only the interval counter runs; wake when interval elapses
// R9 - periodic measurements repeat until power-down code 00000 is written
// R10 - periodic code written in periodic mode restarts measurement, keeps status and results
// R11 - periodic mode sets ready on entering interval sleep after a good measurement
// R12 - first result or second status read starts a read, clears ready and overrun
// R13 - results are locked from read start until the second status register is read
// R14 - host must end every data read by reading the second status register
// R15 - host polls the ready flag or watches the pin, then reads status and data
// R16 - unread result overtaken: keep ready, store newer result, set overrun
// R17 - read in progress when next result completes: keep old, drop new, set overrun
// R18 - overflow flag set when summed absolute field reaches 4912 uT, refreshed on store
// R19 - code 10000 energises the internal source, measures once like single mode
// R20 - host judges self-test: X,Y in -200..+200, Z in -800..-200
// R21 - host selects power-down and waits 100 us before another mode code
// R22 - measurement and interval counts derive from the clock; interval starts at measurement start
package mag_seq_pkg;

  localparam int CLOCK_HZ    = 50_000_000;
  localparam int MEAS_TIME_US = 2000;
  localparam int US_PER_S    = 1_000_000;
  localparam int CNT_W       = 26;

  localparam int RATE_MODE1_HZ = 10;
  localparam int RATE_MODE2_HZ = 20;
  localparam int RATE_MODE3_HZ = 50;
  localparam int RATE_MODE4_HZ = 100;
  localparam int RATE_MODE5_HZ = 200;
  localparam int RATE_MODE6_HZ = 1;

  localparam logic [4:0] MODE_OFF      = 5'h00;
  localparam logic [4:0] MODE_SINGLE   = 5'h01;
  localparam logic [4:0] MODE_PERIOD1  = 5'h02;
  localparam logic [4:0] MODE_PERIOD2  = 5'h04;
  localparam logic [4:0] MODE_PERIOD3  = 5'h06;
  localparam logic [4:0] MODE_PERIOD4  = 5'h08;
  localparam logic [4:0] MODE_PERIOD5  = 5'h0A;
  localparam logic [4:0] MODE_PERIOD6  = 5'h0C;
  localparam logic [4:0] MODE_SELFTEST = 5'h10;

  localparam logic [7:0] FIRST_STATUS_ADDR  = 8'h00;
  localparam logic [7:0] X_RESULT_LOW_ADDR  = 8'h04;
  localparam logic [7:0] X_RESULT_HIGH_ADDR = 8'h08;
  localparam logic [7:0] Y_RESULT_LOW_ADDR  = 8'h0C;
  localparam logic [7:0] Y_RESULT_HIGH_ADDR = 8'h10;
  localparam logic [7:0] Z_RESULT_LOW_ADDR  = 8'h14;
  localparam logic [7:0] Z_RESULT_HIGH_ADDR = 8'h18;
  localparam logic [7:0] TEMP_SPARE_ADDR    = 8'h1C;
  localparam logic [7:0] SECOND_STATUS_ADDR = 8'h20;
  localparam logic [7:0] CONTROL_TWO_ADDR   = 8'h24;

  localparam int READY_BIT    = 0;
  localparam int OVERRUN_BIT  = 1;
  localparam int OVERFLOW_BIT = 3;

  localparam int FIELD_LIMIT_UT      = 4912;
  localparam int CENTI_UT_PER_LSB    = 15;
  localparam int CENTI_PER_UNIT      = 100;
  localparam logic [23:0] OVF_LIMIT_SCALED = 24'(FIELD_LIMIT_UT * CENTI_PER_UNIT);
  localparam logic [3:0]  OVF_LSB_SCALE    = 4'(CENTI_UT_PER_LSB);

  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    S_IDLE    = 2'b00,
    S_MEASURE = 2'b01,
    S_SLEEP   = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic signed [15:0] x_axis_value;
    logic signed [15:0] y_axis_value;
    logic signed [15:0] z_axis_value;
  } axes_t;

  typedef struct packed {
    seq_state_t       state;
    logic [4:0]       mode;
    logic [CNT_W-1:0] meas_cnt;
    logic [CNT_W-1:0] interval_cnt;
    logic             result_ready_flag;
    logic             result_overrun_flag;
    logic             field_overflow_flag;
    logic             read_lock;
    axes_t            result;
    logic             sensor_on;
    logic             selftest_on;
    apb_rsp_t         rsp;
  } ctrl_state_t;

endpackage

// >>> hw/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] data_in,
  output logic      [WIDTH-1:0] data_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st.first  = data_in;
    next_st.second = st.first;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign data_out = st.second;
endmodule // level_sync
`default_nettype wire

// >>> hw/field_overflow_check.sv
`timescale 1ns/1ps
`default_nettype none
module field_overflow_check import mag_seq_pkg::*; (
  input  wire axes_t axes_in,
  output logic       overflow_out
);
  logic [16:0] abs_x;
  logic [16:0] abs_y;
  logic [16:0] abs_z;
  logic [18:0] abs_sum;
  logic [23:0] scaled;

  // compare in centi-microtesla so the limit needs no rounding
  always_comb begin
    abs_x = axes_in.x_axis_value[15] ? 17'(-$signed({axes_in.x_axis_value[15], axes_in.x_axis_value}))
                                     : 17'(axes_in.x_axis_value);
    abs_y = axes_in.y_axis_value[15] ? 17'(-$signed({axes_in.y_axis_value[15], axes_in.y_axis_value}))
                                     : 17'(axes_in.y_axis_value);
    abs_z = axes_in.z_axis_value[15] ? 17'(-$signed({axes_in.z_axis_value[15], axes_in.z_axis_value}))
                                     : 17'(axes_in.z_axis_value);
    abs_sum      = 19'(abs_x) + 19'(abs_y) + 19'(abs_z);
    scaled       = 24'(abs_sum) * 24'(OVF_LSB_SCALE);
    overflow_out = (scaled >= OVF_LIMIT_SCALED); // R18
  end
endmodule // field_overflow_check
`default_nettype wire

// >>> hw/magnetometer_measurement_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module magnetometer_measurement_sequencer import mag_seq_pkg::*; #(
  parameter int MEAS_CYCLES     = MEAS_TIME_US * (CLOCK_HZ / US_PER_S),
  parameter int INTERVAL1_CYCLES = CLOCK_HZ / RATE_MODE1_HZ,
  parameter int INTERVAL2_CYCLES = CLOCK_HZ / RATE_MODE2_HZ,
  parameter int INTERVAL3_CYCLES = CLOCK_HZ / RATE_MODE3_HZ,
  parameter int INTERVAL4_CYCLES = CLOCK_HZ / RATE_MODE4_HZ,
  parameter int INTERVAL5_CYCLES = CLOCK_HZ / RATE_MODE5_HZ,
  parameter int INTERVAL6_CYCLES = CLOCK_HZ / RATE_MODE6_HZ
) (
  input  wire logic     CLOCK_IN,
  input  wire logic     RST_N_IN,
  input  wire apb_req_t APB_REQ_IN,
  output var  apb_rsp_t APB_RSP_OUT,
  input  wire axes_t    SENSOR_IN,
  output logic          RESULT_READY_OUT,
  output logic          SENSOR_POWER_OUT,
  output logic          SELFTEST_SOURCE_OUT
);

  localparam logic [CNT_W-1:0] MEAS_LAST = CNT_W'(MEAS_CYCLES - 1);

  ctrl_state_t      st;
  ctrl_state_t      next_st;
  axes_t            sensor_sync;
  logic             overflow_calc;
  logic [CNT_W-1:0] period_last;
  logic             setup;
  logic             access;
  logic             rd_access;
  logic             wr_control;
  logic             result_read;
  logic             status2_read;
  logic             meas_done;
  logic             protect;
  logic             periodic_now;
  logic [4:0]       code;

  // the front end is free running; samples are only taken at the end of a measurement,
  // when the converter output has settled, so a plain two-stage sync is adequate
  level_sync #(
    .WIDTH($bits(axes_t))
  ) u_sensor_sync (
    .clk_in  (CLOCK_IN),
    .rst_n_in(RST_N_IN),
    .data_in (SENSOR_IN),
    .data_out(sensor_sync)
  );

  field_overflow_check u_overflow (
    .axes_in     (sensor_sync),
    .overflow_out(overflow_calc)
  );

  function automatic logic is_periodic(input logic [4:0] m);
    case (m)
      MODE_PERIOD1, MODE_PERIOD2, MODE_PERIOD3,
      MODE_PERIOD4, MODE_PERIOD5, MODE_PERIOD6: is_periodic = 1'b1;
      default:                                  is_periodic = 1'b0;
    endcase
  endfunction

  always_comb begin
    case (st.mode) // R7
      MODE_PERIOD1: period_last = CNT_W'(INTERVAL1_CYCLES - 1);
      MODE_PERIOD2: period_last = CNT_W'(INTERVAL2_CYCLES - 1);
      MODE_PERIOD3: period_last = CNT_W'(INTERVAL3_CYCLES - 1);
      MODE_PERIOD4: period_last = CNT_W'(INTERVAL4_CYCLES - 1);
      MODE_PERIOD5: period_last = CNT_W'(INTERVAL5_CYCLES - 1);
      MODE_PERIOD6: period_last = CNT_W'(INTERVAL6_CYCLES - 1);
      default:      period_last = '1;
    endcase
  end

  always_comb begin
    setup        = APB_REQ_IN.psel && !APB_REQ_IN.penable;
    access       = APB_REQ_IN.psel && APB_REQ_IN.penable && st.rsp.pready;
    rd_access    = access && !APB_REQ_IN.pwrite;
    wr_control   = access && APB_REQ_IN.pwrite && (APB_REQ_IN.paddr == CONTROL_TWO_ADDR);
    status2_read = rd_access && (APB_REQ_IN.paddr == SECOND_STATUS_ADDR);
    result_read  = rd_access && (APB_REQ_IN.paddr >= X_RESULT_LOW_ADDR)
                             && (APB_REQ_IN.paddr <= SECOND_STATUS_ADDR)
                             && (APB_REQ_IN.paddr[1:0] == 2'b00);
    meas_done    = (st.state == S_MEASURE) && (st.meas_cnt == MEAS_LAST);
    // a read that begins in the completion cycle already saw the old data
    protect      = st.read_lock || result_read; // R13 R17
    periodic_now = is_periodic(st.mode);
    code         = APB_REQ_IN.pwdata[4:0];
  end

  always_comb begin
    next_st             = st;
    next_st.rsp.pready  = 1'b0;
    next_st.rsp.pslverr = 1'b0;

    // register read data is prepared in the setup cycle, answered with no wait state
    if (setup) begin
      next_st.rsp.pready = 1'b1;
      next_st.rsp.prdata = READ_ZERO;
      case (APB_REQ_IN.paddr)
        FIRST_STATUS_ADDR: begin
          next_st.rsp.prdata[READY_BIT]   = st.result_ready_flag;
          next_st.rsp.prdata[OVERRUN_BIT] = st.result_overrun_flag;
        end
        X_RESULT_LOW_ADDR:  next_st.rsp.prdata[7:0] = st.result.x_axis_value[7:0];
        X_RESULT_HIGH_ADDR: next_st.rsp.prdata[7:0] = st.result.x_axis_value[15:8];
        Y_RESULT_LOW_ADDR:  next_st.rsp.prdata[7:0] = st.result.y_axis_value[7:0];
        Y_RESULT_HIGH_ADDR: next_st.rsp.prdata[7:0] = st.result.y_axis_value[15:8];
        Z_RESULT_LOW_ADDR:  next_st.rsp.prdata[7:0] = st.result.z_axis_value[7:0];
        Z_RESULT_HIGH_ADDR: next_st.rsp.prdata[7:0] = st.result.z_axis_value[15:8];
        TEMP_SPARE_ADDR:    next_st.rsp.prdata      = READ_ZERO;
        SECOND_STATUS_ADDR: next_st.rsp.prdata[OVERFLOW_BIT] = st.field_overflow_flag;
        CONTROL_TWO_ADDR:   next_st.rsp.prdata[4:0] = st.mode;
        default:            next_st.rsp.pslverr = 1'b1;
      endcase
    end

    // read side effects; a completion below may set the overrun flag again and then wins
    if (result_read) begin
      next_st.result_ready_flag = 1'b0; // R3
      if (!st.read_lock) begin
        next_st.result_overrun_flag = 1'b0; // R12
        next_st.read_lock           = 1'b1; // R13
      end
    end
    if (status2_read) begin
      next_st.read_lock = 1'b0; // R13
    end

    case (st.state)
      S_IDLE: begin
        next_st.meas_cnt     = '0;
        next_st.interval_cnt = '0;
      end
      S_MEASURE: begin
        next_st.meas_cnt     = st.meas_cnt + 1'b1;
        next_st.interval_cnt = st.interval_cnt + 1'b1; // R22
        if (meas_done) begin
          if (protect) begin
            next_st.result_overrun_flag = 1'b1; // R17
          end else begin
            if (st.result_ready_flag && !result_read) begin
              next_st.result_overrun_flag = 1'b1; // R16
            end
            next_st.result              = sensor_sync; // R6
            next_st.field_overflow_flag = overflow_calc; // R18
            next_st.result_ready_flag   = 1'b1; // R2 R11 R16
          end
          if (periodic_now) begin
            next_st.state = S_SLEEP; // R8
          end else begin
            next_st.state = S_IDLE; // R1 R19
            next_st.mode  = MODE_OFF; // R1
          end
        end
      end
      S_SLEEP: begin
        next_st.interval_cnt = st.interval_cnt + 1'b1; // R8
        if (st.interval_cnt >= period_last) begin
          next_st.state        = S_MEASURE; // R8 R9
          next_st.meas_cnt     = '0;
          next_st.interval_cnt = '0;
        end
      end
      default: begin
        next_st.state = S_IDLE;
      end
    endcase

    // a mode write overrides the sequencing above but never touches flags or results
    if (wr_control) begin // R4
      if (code == MODE_OFF) begin
        next_st.mode  = MODE_OFF; // R9
        next_st.state = S_IDLE;
      end else if ((st.state == S_IDLE &&
                    (code == MODE_SINGLE || code == MODE_SELFTEST || is_periodic(code))) ||
                   (periodic_now && is_periodic(code))) begin
        next_st.mode         = code; // R10
        next_st.state        = S_MEASURE;
        next_st.meas_cnt     = '0;
        next_st.interval_cnt = '0;
      end
    end

    next_st.sensor_on   = (next_st.state == S_MEASURE);
    next_st.selftest_on = (next_st.state == S_MEASURE) && (next_st.mode == MODE_SELFTEST); // R19
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign APB_RSP_OUT         = st.rsp;
  assign RESULT_READY_OUT    = st.result_ready_flag; // R5
  assign SENSOR_POWER_OUT    = st.sensor_on;
  assign SELFTEST_SOURCE_OUT = st.selftest_on;

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  sequence seq_single_done;
    meas_done && !periodic_now;
  endsequence

  sequence seq_clean_store;
    meas_done && !protect;
  endsequence

  sequence seq_back_in_idle;
    (st.state == S_IDLE) && (st.mode == MODE_OFF) && !st.sensor_on;
  endsequence

  chk_pin_tracks_flag: assert property ( // R5
    RESULT_READY_OUT == st.result_ready_flag && (!RESULT_READY_OUT || !$rose(st.read_lock)))
    else $error("ready pin differs from ready flag");

  chk_single_to_idle: assert property ( // R1
    seq_single_done and !wr_control |=> seq_back_in_idle)
    else $error("single measurement did not return to power-down");

  chk_single_ready: assert property ( // R2
    seq_single_done ##0 seq_clean_store |=> st.result_ready_flag ##0 seq_back_in_idle)
    else $error("ready flag not set at single completion");

  chk_read_clears: assert property ( // R3
    result_read && !meas_done |=> !st.result_ready_flag && st.read_lock == !$past(status2_read)
      && (!st.result_overrun_flag || $past(st.read_lock)))
    else $error("result read left ready or overrun set");

  chk_ready_kept: assert property ( // R4
    st.result_ready_flag && wr_control && !result_read |=> st.result_ready_flag)
    else $error("mode change cleared the ready flag");

  chk_hold_measure: assert property ( // R6
    (st.state == S_MEASURE) && !meas_done |=> $stable(st.result))
    else $error("results changed during a measurement");

  chk_lock_holds: assert property ( // R13
    st.read_lock && !status2_read |=> $stable(st.result) && st.read_lock)
    else $error("locked results were updated");

  chk_skip_overrun: assert property ( // R16
    seq_clean_store ##0 st.result_ready_flag |=> st.result_overrun_flag && st.result_ready_flag)
    else $error("overtaken result did not raise overrun");

  chk_locked_drop: assert property ( // R17
    meas_done && st.read_lock |=> st.result_overrun_flag && $stable(st.result))
    else $error("result stored while a read was in progress");

  chk_periodic_sleep: assert property ( // R11
    meas_done && periodic_now && !wr_control |=> (st.state == S_SLEEP) ##0 (st.result_ready_flag || st.result_overrun_flag))
    else $error("periodic completion did not enter sleep with ready or overrun");

  chk_interval_wake: assert property ( // R8
    (st.state == S_SLEEP) && (st.interval_cnt >= period_last) && !wr_control
      |=> (st.state == S_MEASURE) && (st.meas_cnt == '0) ##1 (st.meas_cnt == CNT_W'(1)) || (st.state != S_MEASURE))
    else $error("sleep did not wake when the interval elapsed");

  chk_overflow_store: assert property ( // R18
    seq_clean_store |=> st.field_overflow_flag == $past(overflow_calc))
    else $error("overflow flag not refreshed with the results");

  chk_restart_keeps: assert property ( // R10
    wr_control && periodic_now && is_periodic(code) && !meas_done && !result_read && !status2_read
      |=> (st.state == S_MEASURE) && (st.meas_cnt == '0) && $stable(st.result)
          && $stable(st.result_ready_flag) && $stable(st.result_overrun_flag))
    else $error("periodic rewrite did not restart cleanly");

  chk_off_stops: assert property ( // R9
    wr_control && (code == MODE_OFF) |=> (st.state == S_IDLE) [*2])
    else $error("power-down write did not stop measurements");

endmodule // magnetometer_measurement_sequencer
`default_nettype wire

// >>> dv/host_apb_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_apb_model import mag_seq_pkg::*; (
  input  wire apb_rsp_t rsp_in,
  input  wire logic     clk_in,
  output var  apb_req_t req_out
);
  logic err;

  initial req_out = '0;

  // request held from setup until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_in);
    req_out <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_in);
    req_out.penable <= 1'b1;
    do @(posedge clk_in); while (rsp_in.pready !== 1'b1);
    err = rsp_in.pslverr;
    q   = rsp_in.prdata;
    req_out <= '0;
    // callers look at design outputs only once they have settled
    @(negedge clk_in);
  endtask

  // power-down first, then the settling time before any new mode
  task automatic set_mode(input logic [4:0] m);
    logic [31:0] q;
    xfer(1'b1, CONTROL_TWO_ADDR, READ_ZERO, q);
    repeat (5000) @(posedge clk_in);
    xfer(1'b1, CONTROL_TWO_ADDR, {27'h0, m}, q);
  endtask

  // results first, second status last so the lock is always released
  task automatic read_all(output axes_t r, output logic [31:0] st2);
    logic [31:0] v [6];
    for (int i = 0; i < 6; i++) xfer(1'b0, X_RESULT_LOW_ADDR + 8'(4 * i), READ_ZERO, v[i]);
    xfer(1'b0, SECOND_STATUS_ADDR, READ_ZERO, st2);
    r = {v[1][7:0], v[0][7:0], v[3][7:0], v[2][7:0], v[5][7:0], v[4][7:0]};
  endtask

  function automatic logic selftest_ok(input axes_t r);
    return r.x_axis_value >= -200 && r.x_axis_value <= 200 &&
           r.y_axis_value >= -200 && r.y_axis_value <= 200 &&
           r.z_axis_value >= -800 && r.z_axis_value <= -200;
  endfunction
endmodule // host_apb_model
`default_nettype wire

// >>> dv/magnetometer_measurement_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module magnetometer_measurement_sequencer_bench
  import mag_seq_pkg::*;
();
  localparam int MEAS = 20;
  localparam int IV [6] = '{40, 50, 60, 70, 80, 90};
  localparam logic [4:0] CODE [6] = '{MODE_PERIOD1, MODE_PERIOD2, MODE_PERIOD3,
                                      MODE_PERIOD4, MODE_PERIOD5, MODE_PERIOD6};
  localparam logic [47:0] OVF_IN [3] = '{48'h7FFF_0000_0000, 48'h7FEA_0000_0000,
                                         48'h0000_0000_8015};
  localparam logic OVF_EXP [3] = '{1'b1, 1'b0, 1'b1};
  logic        clock;
  logic        rst_n;
  apb_req_t    req;
  apb_rsp_t    rsp;
  axes_t       sensor;
  logic        ready;
  logic        power;
  logic        source;
  int          fails;
  int          checks_done;
  logic [31:0] q;
  axes_t       r;
  int          n;

  magnetometer_measurement_sequencer #(
    .MEAS_CYCLES(MEAS), .INTERVAL1_CYCLES(IV[0]), .INTERVAL2_CYCLES(IV[1]),
    .INTERVAL3_CYCLES(IV[2]), .INTERVAL4_CYCLES(IV[3]), .INTERVAL5_CYCLES(IV[4]),
    .INTERVAL6_CYCLES(IV[5])
  ) DUT (
    .CLOCK_IN(clock), .RST_N_IN(rst_n), .APB_REQ_IN(req), .APB_RSP_OUT(rsp),
    .SENSOR_IN(sensor), .RESULT_READY_OUT(ready), .SENSOR_POWER_OUT(power),
    .SELFTEST_SOURCE_OUT(source)
  );

  host_apb_model host (.rsp_in(rsp), .clk_in(clock), .req_out(req));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
    host.xfer(1'b0, a, READ_ZERO, q);
    check(name, {16'h0, q}, {40'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [4:0] d);
    host.xfer(1'b1, a, {27'h0, d}, q);
  endtask

  // counts falling edges until the sensor power pin reaches lvl
  task automatic wait_pw(input logic lvl, output int c);
    c = 0;
    do begin
      @(negedge clock);
      c++;
    end while (power !== lvl && c < 1000);
  endtask

  task automatic wait_ready();
    int c;
    c = 0;
    while (ready !== 1'b1 && c < 500) begin
      @(negedge clock);
      c++;
    end
    check("ready wait", 48'(c < 500), 48'h1);
  endtask

  task automatic put(input axes_t v);
    @(posedge clock);
    sensor <= v;
  endtask

  task automatic t_reset();
    rd_chk(FIRST_STATUS_ADDR, 8'h00, "status");
    rd_chk(CONTROL_TWO_ADDR, 8'h00, "mode");
    rd_chk(X_RESULT_LOW_ADDR, 8'h00, "x low");
    wr(FIRST_STATUS_ADDR, 5'h03);
    rd_chk(FIRST_STATUS_ADDR, 8'h00, "status ro");
    rd_chk(TEMP_SPARE_ADDR, 8'h00, "spare");
    host.xfer(1'b0, 8'h28, READ_ZERO, q);
    check("unmapped", {47'h0, host.err}, 48'h1);
    $display("test reset done");
  endtask

  task automatic t_single();
    put(48'h0123_FFF0_FE00);
    repeat (3) @(posedge clock);
    wr(CONTROL_TWO_ADDR, MODE_SINGLE);
    rd_chk(CONTROL_TWO_ADDR, 8'h01, "mode run");
    rd_chk(X_RESULT_LOW_ADDR, 8'h00, "x kept");
    rd_chk(SECOND_STATUS_ADDR, 8'h00, "st2 idle");
    wait_ready();
    check("power off", {47'h0, power}, 48'h0);
    rd_chk(FIRST_STATUS_ADDR, 8'h01, "ready bit");
    rd_chk(CONTROL_TWO_ADDR, 8'h00, "mode cleared");
    host.read_all(r, q);
    check("axes", r, 48'h0123_FFF0_FE00);
    check("ready pin", {47'h0, ready}, 48'h0);
    $display("test single done");
  endtask

  task automatic t_selftest();
    put(48'h000A_FFEC_FE0C);
    host.set_mode(MODE_SELFTEST);
    wait_pw(1'b1, n);
    check("source on", {47'h0, source}, 48'h1);
    wait_ready();
    check("source off", {47'h0, source}, 48'h0);
    rd_chk(CONTROL_TWO_ADDR, 8'h00, "st mode");
    host.set_mode(MODE_SINGLE);
    check("ready kept", {47'h0, ready}, 48'h1);
    wait_pw(1'b1, n);
    wait_pw(1'b0, n);
    host.read_all(r, q);
    check("st axes", r, 48'h000A_FFEC_FE0C);
    check("verdict", {47'h0, host.selftest_ok(r)}, 48'h1);
    $display("test selftest done");
  endtask

  task automatic t_periodic();
    int b;
    int c;
    for (int i = 0; i < 6; i++) begin
      // power is already up when the mode write returns
      host.set_mode(CODE[i]);
      wait_pw(1'b0, b);
      check("meas len", 48'(b), 48'(MEAS));
      check("ready set", {47'h0, ready}, 48'h1);
      wait_pw(1'b1, c);
      check("interval", 48'(b + c), 48'(IV[i]));
      put({16'(i + 1), 32'h0});
      wait_pw(1'b0, n);
      rd_chk(FIRST_STATUS_ADDR, 8'h03, "overrun");
      host.read_all(r, q);
      check("newer", r, {16'(i + 1), 32'h0});
      rd_chk(FIRST_STATUS_ADDR, 8'h00, "cleared");
      wr(CONTROL_TWO_ADDR, MODE_OFF);
      wait_pw(1'b0, n);
      wait_pw(1'b1, n);
      check("stopped", 48'(n), 48'd1000);
    end
    $display("test periodic done");
  endtask

  task automatic t_lock();
    put(48'h0111_0000_0000);
    host.set_mode(MODE_PERIOD1);
    wait_ready();
    rd_chk(X_RESULT_LOW_ADDR, 8'h11, "x first");
    check("ready low", {47'h0, ready}, 48'h0);
    put(48'h0222_0000_0000);
    wait_pw(1'b1, n);
    wait_pw(1'b0, n);
    rd_chk(X_RESULT_LOW_ADDR, 8'h11, "x held");
    rd_chk(FIRST_STATUS_ADDR, 8'h02, "dropped");
    rd_chk(SECOND_STATUS_ADDR, 8'h00, "unlock");
    wr(CONTROL_TWO_ADDR, MODE_PERIOD1);
    wait_pw(1'b1, n);
    check("restart", 48'(n <= 2), 48'h1);
    rd_chk(FIRST_STATUS_ADDR, 8'h02, "kept");
    wait_pw(1'b0, n);
    rd_chk(X_RESULT_LOW_ADDR, 8'h22, "x new");
    rd_chk(FIRST_STATUS_ADDR, 8'h00, "start clr");
    rd_chk(SECOND_STATUS_ADDR, 8'h00, "end read");
    wr(CONTROL_TWO_ADDR, MODE_OFF);
    $display("test lock done");
  endtask

  task automatic t_overflow();
    for (int i = 0; i < 3; i++) begin
      put(OVF_IN[i]);
      host.set_mode(MODE_SINGLE);
      wait_ready();
      host.read_all(r, q);
      check("overflow", {47'h0, q[OVERFLOW_BIT]}, {47'h0, OVF_EXP[i]});
    end
    $display("test overflow done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    sensor = '0;
    fails = 0;
    checks_done = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_single();
    t_selftest();
    t_periodic();
    t_lock();
    t_overflow();
    tally_and_finish();
  end

  // about 70000 cycles expected, most of it mode settling waits
  initial begin
    repeat (90000) @(posedge clock);
    fails++;
    tally_and_finish();
  end
endmodule // magnetometer_measurement_sequencer_bench
`default_nettype wire
